// ### itc_interval_timer.sv
`timescale 1ns/1ps
`include "itc_map.svh"

// Function
// - intervals from 1/128 second to 255 hours
// - counter runs from oscillator, even in power-down
// - selected unit overflow advances interval counter
// - match with compare value sets flag, interrupt
// - match while asleep and enabled wakes core
// - control at A1H, resets to 00H
// - control fields: format, units, single, flag, enables
// - hour wraps at 23 or at 255
// - core reset keeps counting, clears hour format
module itc_interval_timer import itc_pkg::*; #(
  parameter int TICK_CYCLES = `ITC_TICK_NS / `ITC_CLK_NS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // core state
  input wire logic coreReset,
  input wire logic coreSleep,
  input wire logic irqEnable,
  // special function register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWr,
  input wire logic sfrRd,
  input wire logic [7:0] sfrWdata,
  output logic [7:0] sfrRdata,
  // interrupt and wake
  output logic irqReq,
  output logic wakeUp,
  output logic [15:0] wakeVector
);

  logic [6:0] ctrl;
  logic [6:0] hth;
  logic [5:0] sec;
  logic [5:0] min;
  logic [7:0] hour;
  logic [7:0] cmpVal;
  logic [7:0] icnt;
  logic [7:0] next_icnt;
  logic tick;
  logic secWrap;
  logic minWrap;
  logic hourWrap;
  logic unitEvent;
  logic match;
  logic cntEn;
  logic intEn;
  logic matchFlag;
  logic oneShot;
  logic fmt24;
  itc_unit_e unitSel;

  assign cntEn = ctrl[`ITC_B_CNT_EN];
  assign intEn = ctrl[`ITC_B_INT_EN];
  assign matchFlag = ctrl[`ITC_B_FLAG];
  assign oneShot = ctrl[`ITC_B_ONE_SHOT];
  assign fmt24 = ctrl[`ITC_B_FMT24];
  assign unitSel = itc_unit_e'(ctrl[`ITC_B_UNIT_HI:`ITC_B_UNIT_LO]);

  // ----------------------------------------
  // time base
  // ----------------------------------------
  // ticks keep coming while the core sleeps; only the clock enable stops them
  itc_tick_div #(.CYCLES(TICK_CYCLES)) u_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .run(cntEn),
    .tick(tick)
  );

  assign secWrap = tick && hth == `ITC_HTH_MAX;
  assign minWrap = secWrap && sec == `ITC_SEC_MAX;
  assign hourWrap = minWrap && min == `ITC_MIN_MAX;

  // ----------------------------------------
  // time counters
  // ----------------------------------------
  // a software load beats the count in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hth <= 7'h00;
      sec <= 6'h00;
      min <= 6'h00;
    end else begin
      if (sfrWr && sfrAddr == `ITC_HTH_ADDR) begin
        hth <= sfrWdata[6:0];
      end else if (tick) begin
        hth <= hth + 7'h01;
      end
      if (sfrWr && sfrAddr == `ITC_SEC_ADDR) begin
        sec <= sfrWdata[5:0];
      end else if (secWrap) begin
        sec <= 6'(itc_step({2'b00, sec}, {2'b00, `ITC_SEC_MAX}));
      end
      if (sfrWr && sfrAddr == `ITC_MIN_ADDR) begin
        min <= sfrWdata[5:0];
      end else if (minWrap) begin
        min <= 6'(itc_step({2'b00, min}, {2'b00, `ITC_MIN_MAX}));
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hour <= 8'h00;
    end else if (sfrWr && sfrAddr == `ITC_HOUR_ADDR) begin
      hour <= sfrWdata;
    end else if (hourWrap) begin
      // out-of-range preload in 24 h form also folds back to zero
      hour <= (fmt24 && hour >= `ITC_HOUR24_MAX) ? 8'h00 : 8'(hour + 8'h01);
    end
  end

  // ----------------------------------------
  // interval counter
  // ----------------------------------------
  always_comb begin
    case (unitSel)
      ITC_UNIT_TICK: unitEvent = tick;
      ITC_UNIT_SEC: unitEvent = secWrap;
      ITC_UNIT_MIN: unitEvent = minWrap;
      ITC_UNIT_HOUR: unitEvent = hourWrap;
      default: unitEvent = 1'b0;
    endcase
  end

  // 8-bit compare in hour units gives the 255 h ceiling
  assign next_icnt = 8'(icnt + 8'h01);
  assign match = intEn && unitEvent && next_icnt == cmpVal;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      icnt <= 8'h00;
    end else if (!intEn || match) begin
      icnt <= 8'h00;
    end else if (unitEvent) begin
      icnt <= next_icnt;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmpVal <= 8'h00;
    end else if (sfrWr && sfrAddr == `ITC_CMP_ADDR) begin
      cmpVal <= sfrWdata;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= `ITC_CTRL_RESET;
    end else begin
      if (sfrWr && sfrAddr == `ITC_CTRL_ADDR) begin
        ctrl <= sfrWdata[6:0];
      end
      if (coreReset) begin
        ctrl[`ITC_B_FMT24] <= 1'b0;
      end
      if (match && oneShot) begin
        ctrl[`ITC_B_INT_EN] <= 1'b0;
      end
      // set wins over a software clear in the same cycle
      if (match) begin
        ctrl[`ITC_B_FLAG] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // read port and interrupt outputs
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sfrRdata <= 8'h00;
    end else if (sfrRd) begin
      case (sfrAddr)
        `ITC_CTRL_ADDR: sfrRdata <= {1'b0, ctrl};
        `ITC_HTH_ADDR: sfrRdata <= {1'b0, hth};
        `ITC_SEC_ADDR: sfrRdata <= {2'b00, sec};
        `ITC_MIN_ADDR: sfrRdata <= {2'b00, min};
        `ITC_HOUR_ADDR: sfrRdata <= hour;
        `ITC_CMP_ADDR: sfrRdata <= cmpVal;
        default: sfrRdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irqReq <= 1'b0;
      wakeUp <= 1'b0;
      wakeVector <= 16'h0000;
    end else begin
      irqReq <= matchFlag && irqEnable;
      wakeUp <= matchFlag && irqEnable && coreSleep;
      wakeVector <= (matchFlag && irqEnable) ? `ITC_WAKE_VECTOR : 16'h0000;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sleep_count_a: assert property (@(posedge core_clk) disable iff (!nrst)
    tick && coreSleep && !sfrWr |=> hth == 7'($past(hth) + 7'h01))
    else $error("time base stalled in sleep");

  unit_advance_a: assert property (@(posedge core_clk) disable iff (!nrst)
    unitEvent && intEn && !match |=> icnt == 8'($past(icnt) + 8'h01))
    else $error("interval counter did not advance");

  match_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
    match |=> matchFlag ##1 irqReq == $past(irqEnable))
    else $error("match flag or request missing");

  wake_vector_a: assert property (@(posedge core_clk) disable iff (!nrst)
    matchFlag && irqEnable && coreSleep |=> wakeUp && wakeVector == `ITC_WAKE_VECTOR)
    else $error("no wake on match");

  ctrl_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    sfrRd && sfrAddr == `ITC_CTRL_ADDR |=> sfrRdata[7] == 1'b0 && sfrRdata[6:0] == $past(ctrl))
    else $error("control read wrong");

  unit_decode_a: assert property (@(posedge core_clk) disable iff (!nrst)
    unitSel == ITC_UNIT_HOUR |-> unitEvent == hourWrap)
    else $error("unit select decode wrong");

  hour_wrap_a: assert property (@(posedge core_clk) disable iff (!nrst)
    hourWrap && !sfrWr && hour == 8'h17 |=> hour == ($past(fmt24) ? 8'h00 : 8'h18))
    else $error("hour wrap wrong");

  core_reset_a: assert property (@(posedge core_clk) disable iff (!nrst)
    coreReset && !sfrWr |=> !fmt24 && cntEn == $past(cntEn))
    else $error("core reset handling wrong");

  restart_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
    match |=> icnt == 8'h00)
    else $error("interval counter not restarted");

  match_cov: cover property (@(posedge core_clk) disable iff (!nrst) match);
  wake_cov: cover property (@(posedge core_clk) disable iff (!nrst) wakeUp);
  hour24_cov: cover property (@(posedge core_clk) disable iff (!nrst)
    hourWrap && fmt24 && hour == 8'h17);
  single_cov: cover property (@(posedge core_clk) disable iff (!nrst) match && oneShot);

endmodule // itc_interval_timer

// ### itc_map.svh
`ifndef ITC_MAP_SVH
`define ITC_MAP_SVH

// ----------------------------------------
// special function register addresses
// ----------------------------------------
`define ITC_CTRL_ADDR 8'ha1
`define ITC_HTH_ADDR 8'ha2
`define ITC_SEC_ADDR 8'ha3
`define ITC_MIN_ADDR 8'ha4
`define ITC_HOUR_ADDR 8'ha5
`define ITC_CMP_ADDR 8'ha6

// ----------------------------------------
// control register fields and reset
// ----------------------------------------
`define ITC_B_CNT_EN 0
`define ITC_B_INT_EN 1
`define ITC_B_FLAG 2
`define ITC_B_ONE_SHOT 3
`define ITC_B_UNIT_LO 4
`define ITC_B_UNIT_HI 5
`define ITC_B_FMT24 6
`define ITC_CTRL_RESET 7'h00

// ----------------------------------------
// counter limits and vector
// ----------------------------------------
`define ITC_HTH_MAX 7'h7f
`define ITC_SEC_MAX 6'h3b
`define ITC_MIN_MAX 6'h3b
`define ITC_HOUR24_MAX 8'h17
`define ITC_WAKE_VECTOR 16'h0053

// ----------------------------------------
// timing
// ----------------------------------------
`define ITC_TICK_NS 7812500
`define ITC_CLK_NS 5

`endif

// ### itc_pkg.sv
package itc_pkg;

  // interval unit select encoding
  typedef enum logic [1:0] {
    ITC_UNIT_TICK = 2'h0,
    ITC_UNIT_SEC = 2'h1,
    ITC_UNIT_MIN = 2'h2,
    ITC_UNIT_HOUR = 2'h3
  } itc_unit_e;

  // next value of a wrapping counter
  function automatic logic [7:0] itc_step(input logic [7:0] val, input logic [7:0] top);
    itc_step = (val == top) ? 8'h00 : 8'(val + 8'h01);
  endfunction

endpackage

// ### itc_tick_div.sv
`timescale 1ns/1ps
module itc_tick_div import itc_pkg::*; #(
  parameter int CYCLES = 1562500
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // control
  input wire logic run,
  // 1/128 s pulse
  output logic tick
);

  localparam int W = $clog2(CYCLES);
  logic [W-1:0] cnt;
  logic [31:0] gap;

  // ----------------------------------------
  // divider
  // ----------------------------------------
  // held at zero while stopped, so the first tick is a full period after start
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (!run || cnt == W'(CYCLES - 1)) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  assign tick = run && (cnt == W'(CYCLES - 1));

  // ----------------------------------------
  // checks
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gap <= 32'h0;
    end else if (!run || tick) begin
      gap <= 32'h0;
    end else begin
      gap <= gap + 32'h1;
    end
  end

  tick_period_a: assert property (@(posedge core_clk) disable iff (!nrst)
    tick |-> gap == 32'(CYCLES - 1)) else $error("tick period wrong");

endmodule // itc_tick_div

// ### itc_interval_timer_tb.sv
`timescale 1ns/1ps
`include "itc_map.svh"
`define CHK(what, exp, got) \
  begin \
    checksDone++; \
    if ((got) !== (exp)) begin \
      errTotal++; \
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module itc_interval_timer_tb import itc_pkg::*; ;
  // --------------------------------
  // clock, reset and design ports
  // --------------------------------
  // short tick period keeps the run small
  localparam int TC = 4;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic coreReset = 1'b0;
  logic coreSleep = 1'b0;
  logic irqEnable = 1'b0;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWr = 1'b0;
  logic sfrRd = 1'b0;
  logic [7:0] sfrWdata = 8'h00;
  logic [7:0] sfrRdata;
  logic irqReq;
  logic wakeUp;
  logic [15:0] wakeVector;
  logic [7:0] rv;
  logic [7:0] h0;
  int n;
  int errTotal = 0;
  int checksDone = 0;

  always #2.5 core_clk = ~core_clk;

  itc_interval_timer #(.TICK_CYCLES(TC)) u_itc_interval_timer (
    .core_clk(core_clk), .nrst(nrst), .coreReset(coreReset), .coreSleep(coreSleep),
    .irqEnable(irqEnable), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .irqReq(irqReq), .wakeUp(wakeUp),
    .wakeVector(wakeVector)
  );

  // --------------------------------
  // register port and helpers
  // --------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfrAddr = a;
    sfrWdata = d;
    sfrWr = 1'b1;
    @(negedge core_clk);
    sfrWr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    sfrAddr = a;
    sfrRd = 1'b1;
    @(negedge core_clk);
    sfrRd = 1'b0;
    d = sfrRdata;
  endtask

  // bounded wait, so a lost match shows as a wrong count, not a hang
  task automatic waitIrq(output int cyc);
    cyc = 0;
    while (irqReq !== 1'b1 && cyc < 3000) begin
      @(negedge core_clk);
      cyc++;
    end
  endtask

  task automatic endOfTest;
    $display("checks %0d errors %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic testReset;
    rd(`ITC_CTRL_ADDR, rv);
    `CHK("ctrl reset", 8'h00, rv)
    `CHK("irq reset", 1'b0, irqReq)
    wr(8'ha7, 8'hff);
    rd(8'ha7, rv);
    `CHK("unmapped", 8'h00, rv)
    wr(`ITC_CTRL_ADDR, 8'hf8);
    rd(`ITC_CTRL_ADDR, rv);
    `CHK("ctrl fields", 8'h78, rv)
    wr(`ITC_CTRL_ADDR, 8'h00);
  endtask

  task automatic testTicks;
    irqEnable = 1'b1;
    wr(`ITC_CMP_ADDR, 8'h03);
    wr(`ITC_CTRL_ADDR, 8'h03);
    waitIrq(n);
    `CHK("first match", 1'b1, n >= 3 * TC && n <= 3 * TC + 4)
    `CHK("vector", `ITC_WAKE_VECTOR, wakeVector)
    `CHK("awake", 1'b0, wakeUp)
    coreSleep = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("wake", 1'b1, wakeUp)
    coreSleep = 1'b0;
    wr(`ITC_CTRL_ADDR, 8'h03);
    @(negedge core_clk);
    `CHK("flag clear", 1'b0, irqReq)
    waitIrq(n);
    // counter restarted at the match, so matches stay one interval apart
    `CHK("match gap", 3 * TC, n + 5)
    irqEnable = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK("masked", 1'b0, irqReq)
    rd(`ITC_CTRL_ADDR, rv);
    `CHK("flag set", 8'h07, rv)
    wr(`ITC_CTRL_ADDR, 8'h0b);
    irqEnable = 1'b1;
    waitIrq(n);
    `CHK("single match", 1'b1, n <= 3 * TC + 4)
    rd(`ITC_CTRL_ADDR, rv);
    `CHK("single stop", 8'h0d, rv)
  endtask

  task automatic testUnits;
    for (int u = 1; u < 4; u++) begin
      wr(`ITC_CTRL_ADDR, 8'h00);
      wr(`ITC_HTH_ADDR, 8'h7e);
      wr(`ITC_SEC_ADDR, 8'h3b);
      wr(`ITC_MIN_ADDR, 8'h3b);
      wr(`ITC_CMP_ADDR, 8'h01);
      wr(`ITC_CTRL_ADDR, {2'b00, 2'(u), 4'h3});
      waitIrq(n);
      `CHK("unit match", 1'b1, n >= 2 * TC && n <= 2 * TC + 4)
      rd(`ITC_SEC_ADDR, rv);
      `CHK("sec wrap", 8'h00, rv)
    end
  endtask

  task automatic testHours;
    for (int f = 0; f < 2; f++) begin
      wr(`ITC_CTRL_ADDR, 8'h00);
      wr(`ITC_HOUR_ADDR, `ITC_HOUR24_MAX);
      wr(`ITC_MIN_ADDR, 8'h3b);
      wr(`ITC_SEC_ADDR, 8'h3b);
      wr(`ITC_HTH_ADDR, 8'h7f);
      wr(`ITC_CTRL_ADDR, f == 0 ? 8'h41 : 8'h01);
      repeat (TC + 4) @(negedge core_clk);
      rd(`ITC_HOUR_ADDR, rv);
      `CHK("hour roll", f == 0 ? 8'h00 : 8'h18, rv)
    end
    wr(`ITC_CTRL_ADDR, 8'h41);
    rd(`ITC_HTH_ADDR, h0);
    @(negedge core_clk);
    coreReset = 1'b1;
    @(negedge core_clk);
    coreReset = 1'b0;
    rd(`ITC_CTRL_ADDR, rv);
    `CHK("fmt cleared", 8'h01, rv)
    repeat (2 * TC) @(negedge core_clk);
    rd(`ITC_HTH_ADDR, rv);
    `CHK("keeps count", 1'b1, rv != h0)
  endtask

  // --------------------------------
  // sequence and watchdog
  // --------------------------------
  initial begin
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    testReset();
    testTicks();
    testUnits();
    testHours();
    endOfTest();
  end

  initial begin
    #(20000 * 5);
    errTotal++;
    endOfTest();
  end
endmodule // itc_interval_timer_tb
